// ---- verilog/down_timer_cfg.svh ----
// Purpose: constants for the down-counting timer with prescaler
// Assumes: one 10 MHz clock, register access through plain ports
// Notes: rules that the timer keeps are listed below
//
// Notes on behaviour
// - Count decrements on each selected tap rising edge; core can load and read it.
// - Decrement to zero sets the zero flag.
// - Zero reached with zero_irq_enable set raises the interrupt request.
// - Prescaler input is internal clock divided by 12 or the timer pin.
// - Tap select picks prescaler input or prescaler bit n-1 as count clock.
// - Prescaler-run low holds prescaler at all ones and stops counting.
// - With prescaler-run high, software may load prescaler with 0 to 7Fh.
// - Gated mode: divided clock counts only while timer pin is high.
// - Event mode: timer pin rising edge decrements the prescaler.
// - Output mode: pin driven from level latch; prescaler uses divided clock.
// - Level latch transparent while zero flag high; holds when it falls.
// - Writing 00h to count or setting status bit 7 sets zero flag.
// - Reset: count 0FFh, prescaler all ones, control/status cleared.
// - Count write beats a simultaneous decrement to 00h; flag stays clear.
// - Count and prescaler state read back through registers that lag count_q and presc_q by one clock.
// - Pending interrupt request can wake the core from wait.
`ifndef DOWN_TIMER_CFG_SVH
`define DOWN_TIMER_CFG_SVH

// ----------------------------------------
// Control/status field positions
// ----------------------------------------
`define TSR_ZERO_BIT 7
`define TSR_IRQEN_BIT 6
`define TSR_PIN_DIRECTION_OUT_BIT 5
`define TSR_LEVEL_BIT 4
`define TSR_RUN_BIT 3
`define TSR_TAP_HI 2
`define TSR_TAP_LO 0

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define COUNT_RESET 8'hff
`define PRESC_RESET 7'h7f
`define TSR_RESET 8'h00
`define INT_DIV 12

`endif

// ---- verilog/down_timer_pkg.sv ----
// Purpose: types shared by the timer files
// Assumes: nothing beyond the config header
// Notes: pin modes follow the direction and level bits
package down_timer_pkg;

    typedef enum logic [2:0] {
        MODE_EVENT = 3'h1,
        MODE_GATED = 3'h2,
        MODE_OUTPUT = 3'h4
    } pin_mode_e;

    typedef struct packed {
        logic wr_count;
        logic [7:0] count_data;
        logic wr_presc;
        logic [6:0] presc_data;
        logic wr_ctrl;
        logic [7:0] ctrl_data;
    } sw_write_s;

endpackage

// ---- verilog/clk_div12.sv ----
// Purpose: one-cycle enable every 12 internal clocks
// Assumes: single clock domain
// Notes: feeds the prescaler input selection
`timescale 1ns/1ps
`include "down_timer_cfg.svh"

module clk_div12 #(
    parameter int DIV = `INT_DIV
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Enable out
    output logic o_tick
);

    logic [3:0] cnt_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 4'h0;
            o_tick <= 1'b0;
        end else if (cnt_q == 4'(DIV - 1)) begin
            cnt_q <= 4'h0;
            o_tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            o_tick <= 1'b0;
        end
    end

endmodule

// ---- verilog/down_timer.sv ----
// Purpose: 8-bit down timer with 7-bit prescaler and timer pin modes
// Assumes: pins synchronous to i_clk; software writes are one-cycle strobes
// Notes: all outputs come from flip-flops
`timescale 1ns/1ps
`include "down_timer_cfg.svh"

module down_timer (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Software writes
    input wire down_timer_pkg::sw_write_s i_wr,
    // Timer pin
    input wire logic i_pin,
    output logic o_pin,
    output logic o_pin_oe,
    // Readback
    output logic [7:0] o_count_value_reg,
    output logic [6:0] o_prescaler_state_reg,
    output logic [7:0] o_timer_control_status_reg,
    // Interrupt and wake
    output logic o_irq,
    output logic o_wake
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [7:0] count_q;
    logic [6:0] presc_q;
    logic [6:0] presc_d;
    logic zero_flag;
    logic zero_irq_enable;
    logic pin_direction_out;
    logic pin_level;
    logic prescaler_run;
    logic [2:0] tap_sel;
    logic level_latch_q;
    logic pin_q;
    logic div_tick;
    logic presc_step;
    logic count_step;
    logic hit_zero;
    down_timer_pkg::pin_mode_e mode;

    clk_div12 u_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .o_tick(div_tick)
    );

    // ----------------------------------------
    // Mode and prescaler input
    // ----------------------------------------
    always_comb begin
        if (pin_direction_out) begin
            mode = down_timer_pkg::MODE_OUTPUT;
        end else if (pin_level) begin
            mode = down_timer_pkg::MODE_GATED;
        end else begin
            mode = down_timer_pkg::MODE_EVENT;
        end
    end

    always_comb begin
        case (mode)
            down_timer_pkg::MODE_EVENT: presc_step = i_pin & ~pin_q;
            down_timer_pkg::MODE_GATED: presc_step = div_tick & i_pin;
            down_timer_pkg::MODE_OUTPUT: presc_step = div_tick;
            default: presc_step = div_tick;
        endcase
        presc_step = presc_step & prescaler_run;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= i_pin;
        end
    end

    // ----------------------------------------
    // Prescaler and tap
    // ----------------------------------------
    assign presc_d = presc_q - 7'h01;

    // Tap n rises when bit n-1 goes 0->1, i.e. on a decrement that wraps it
    always_comb begin
        if (tap_sel == 3'h0) begin
            count_step = presc_step;
        end else begin
            count_step = presc_step & ~presc_q[tap_sel - 3'h1]
                & presc_d[tap_sel - 3'h1];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            presc_q <= `PRESC_RESET;
        end else if (!prescaler_run) begin
            presc_q <= `PRESC_RESET;
        end else if (i_wr.wr_presc) begin
            presc_q <= i_wr.presc_data;
        end else if (presc_step) begin
            presc_q <= presc_d;
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    assign hit_zero = count_step && count_q == 8'h01 && !i_wr.wr_count;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q <= `COUNT_RESET;
        end else if (i_wr.wr_count) begin
            count_q <= i_wr.count_data;
        end else if (count_step) begin
            count_q <= count_q - 8'h01;
        end
    end

    // ----------------------------------------
    // Control/status
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            zero_irq_enable <= 1'b0;
            pin_direction_out <= 1'b0;
            pin_level <= 1'b0;
            prescaler_run <= 1'b0;
            tap_sel <= 3'h0;
        end else if (i_wr.wr_ctrl) begin
            zero_irq_enable <= i_wr.ctrl_data[`TSR_IRQEN_BIT];
            pin_direction_out <= i_wr.ctrl_data[`TSR_PIN_DIRECTION_OUT_BIT];
            pin_level <= i_wr.ctrl_data[`TSR_LEVEL_BIT];
            prescaler_run <= i_wr.ctrl_data[`TSR_RUN_BIT];
            tap_sel <= i_wr.ctrl_data[`TSR_TAP_HI:`TSR_TAP_LO];
        end
    end

    // Hardware set beats software clear in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            zero_flag <= 1'b0;
        end else if (hit_zero) begin
            zero_flag <= 1'b1;
        end else if (i_wr.wr_count && i_wr.count_data == 8'h00) begin
            zero_flag <= 1'b1;
        end else if (i_wr.wr_ctrl) begin
            zero_flag <= i_wr.ctrl_data[`TSR_ZERO_BIT];
        end
    end

    // ----------------------------------------
    // Timer pin
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            level_latch_q <= 1'b0;
        end else if (zero_flag) begin
            level_latch_q <= pin_level;
        end
    end

    // Pin follows level while flag is high, so use the live value then
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin <= 1'b0;
            o_pin_oe <= 1'b0;
        end else begin
            o_pin <= zero_flag ? pin_level : level_latch_q;
            o_pin_oe <= pin_direction_out;
        end
    end

    // ----------------------------------------
    // Readback and interrupt
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_count_value_reg <= `COUNT_RESET;
            o_prescaler_state_reg <= `PRESC_RESET;
            o_timer_control_status_reg <= `TSR_RESET;
            o_irq <= 1'b0;
            o_wake <= 1'b0;
        end else begin
            o_count_value_reg <= count_q;
            o_prescaler_state_reg <= presc_q;
            o_timer_control_status_reg <= {zero_flag, zero_irq_enable, pin_direction_out,
                pin_level, prescaler_run, tap_sel};
            o_irq <= zero_flag & zero_irq_enable;
            o_wake <= zero_flag & zero_irq_enable;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    count_dec_a:
        assert property (count_step && !i_wr.wr_count
        |=> count_q == $past(count_q) - 8'h01) else $error("count not decremented");
    zero_set_a:
        assert property (hit_zero |=> zero_flag)
        else $error("zero flag not set");
    irq_follow_a:
        assert property (zero_flag && zero_irq_enable |=> o_irq)
        else $error("irq missing");
    stop_hold_a:
        assert property (!prescaler_run |=> presc_q == 7'h7f && $stable(count_q)
        || $past(i_wr.wr_count)) else $error("prescaler not held");
    gated_low_a:
        assert property (mode == down_timer_pkg::MODE_GATED && !i_pin
        && !i_wr.wr_presc && prescaler_run |=> $stable(presc_q))
        else $error("gated counted while low");
    write_wins_a:
        assert property (i_wr.wr_count && i_wr.count_data != 8'h00
        && !i_wr.wr_ctrl && !zero_flag |=> !zero_flag && count_q == $past(i_wr.count_data))
        else $error("write did not win");
    wrap_ff_a:
        assert property (count_step && count_q == 8'h00 && !i_wr.wr_count
        |=> count_q == 8'hff) else $error("no wrap");
    zero_write_a:
        assert property (i_wr.wr_count && i_wr.count_data == 8'h00
        |=> zero_flag) else $error("zero write ignored");
    pin_drive_a:
        assert property (zero_flag && pin_direction_out |=> ##1 o_pin_oe
        && o_pin == $past(pin_level, 2)) else $error("pin not driven");

    cov_zero_c: cover property (hit_zero && zero_irq_enable);
    cov_event_c: cover property (mode == down_timer_pkg::MODE_EVENT && count_step);
    cov_out_c: cover property (o_pin_oe && $rose(o_pin));

endmodule

// ---- tb/pin_source.sv ----
// Purpose: signal source on the timer pin
// Assumes: device pin is an input unless o_pin_oe is high
// Notes: level changes 1 ns after the rising clock edge
`timescale 1ns/1ps
module pin_source (
    // Clock
    input wire logic i_clk,
    // Device side of the pin
    input wire logic i_pin_oe,
    input wire logic i_pin_dev,
    // Resolved wire
    output logic o_pin_wire
);
    logic level_q = 1'b0;

    // Device wins the wire while it drives
    assign o_pin_wire = i_pin_oe ? i_pin_dev : level_q;

    // Rising edges for event counting, then settle
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge i_clk) #1;
            level_q = 1'b1;
            @(posedge i_clk) #1;
            level_q = 1'b0;
        end
        repeat (5) @(posedge i_clk);
        #1;
    endtask

    // Level held for n clocks, for gating
    task automatic hold(input logic l, input int n);
        @(posedge i_clk) #1;
        level_q = l;
        repeat (n) @(posedge i_clk);
        #1;
    endtask
endmodule

// ---- tb/down_timer_tb.sv ----
// Purpose: self-checking bench for the down timer
// Assumes: writes are one-cycle strobes, readback two edges later
// Notes: div-by-12 phase unknown, so gated checks use whole periods
`timescale 1ns/1ps
module down_timer_tb;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    down_timer_pkg::sw_write_s i_wr = '0;
    logic pin_wire;
    logic o_pin;
    logic o_pin_oe;
    logic o_irq;
    logic o_wake;
    logic [7:0] cnt;
    logic [6:0] prescaler_state_reg;
    logic [7:0] ctl;
    int err_total = 0;
    int checks = 0;

    initial forever #50 i_clk = ~i_clk;

    down_timer down_timer_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(i_wr),
        .i_pin(pin_wire), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
        .o_count_value_reg(cnt), .o_prescaler_state_reg(prescaler_state_reg),
        .o_timer_control_status_reg(ctl), .o_irq(o_irq), .o_wake(o_wake));

    pin_source pin_source_i (.i_clk(i_clk), .i_pin_oe(o_pin_oe), .i_pin_dev(o_pin),
        .o_pin_wire(pin_wire));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask

    // Kind 0 count, 1 prescaler, 2 control
    task automatic wr(input int k, input logic [7:0] d);
        @(posedge i_clk) #1;
        i_wr.wr_count = (k == 0);
        i_wr.wr_presc = (k == 1);
        i_wr.wr_ctrl = (k == 2);
        i_wr.count_data = d;
        i_wr.presc_data = d[6:0];
        i_wr.ctrl_data = d;
        @(posedge i_clk) #1;
        i_wr = '0;
        @(posedge i_clk) #1;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk("count", 8'hff, cnt);
        chk("presc", 8'h7f, {1'b0, prescaler_state_reg});
        chk("ctrl", 8'h00, ctl);
        chk("oe_irq_wake", 8'h00, {5'h0, o_pin_oe, o_irq, o_wake});
    endtask

    task automatic t_stopped;
        wr(1, 8'h05);
        pin_source_i.pulse(2);
        chk("presc", 8'h7f, {1'b0, prescaler_state_reg});
        chk("count", 8'hff, cnt);
    endtask

    task automatic t_event;
        wr(0, 8'h03);
        wr(2, 8'h48);
        pin_source_i.pulse(2);
        chk("count", 8'h01, cnt);
        chk("ctrl", 8'h48, ctl);
        pin_source_i.pulse(1);
        chk("count", 8'h00, cnt);
        chk("ctrl", 8'hc8, ctl);
        chk("irq_wake", 8'h03, {6'h0, o_irq, o_wake});
        pin_source_i.pulse(1);
        chk("count", 8'hff, cnt);
        chk("presc", 8'h7b, {1'b0, prescaler_state_reg});
        wr(2, 8'h48);
        chk("irq_wake", 8'h00, {6'h0, o_irq, o_wake});
    endtask

    task automatic t_zero_write;
        wr(2, 8'h40);
        wr(0, 8'h00);
        chk("ctrl", 8'hc0, ctl);
        chk("irq", 8'h01, {7'h0, o_irq});
        wr(2, 8'h40);
        wr(2, 8'hc0);
        chk("ctrl", 8'hc0, ctl);
        wr(2, 8'h00);
    endtask

    task automatic t_tap;
        wr(2, 8'h0a);
        wr(1, 8'h07);
        chk("presc", 8'h07, {1'b0, prescaler_state_reg});
        wr(0, 8'h10);
        pin_source_i.pulse(3);
        chk("count", 8'h10, cnt);
        pin_source_i.pulse(1);
        chk("count", 8'h0f, cnt);
    endtask

    task automatic t_gated;
        wr(2, 8'h00);
        wr(0, 8'h20);
        wr(2, 8'h18);
        pin_source_i.hold(1'b0, 48);
        chk("count", 8'h20, cnt);
        // Next hold spends one more edge high, so 48 edges: exactly 4 ticks
        pin_source_i.hold(1'b1, 47);
        pin_source_i.hold(1'b0, 4);
        chk("count", 8'h1c, cnt);
    endtask

    task automatic t_output;
        wr(2, 8'h38);
        chk("oe_pin", 8'h02, {6'h0, o_pin_oe, o_pin});
        wr(2, 8'hb8);
        chk("oe_pin", 8'h03, {6'h0, o_pin_oe, o_pin});
        wr(2, 8'h28);
        chk("pin_held", 8'h01, {7'h0, pin_wire});
        wr(2, 8'ha8);
        chk("pin", 8'h00, {7'h0, o_pin});
    endtask

    // Whole run is about 210 clocks
    initial begin
        #(100 * 5000);
        err_total++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge i_clk);
        #1;
        t_reset();
        i_rst_n = 1'b1;
        @(posedge i_clk) #1;
        t_reset();
        t_stopped();
        t_event();
        t_zero_write();
        t_tap();
        t_gated();
        t_output();
        finish_test();
    end
endmodule
